// ===== bench/metering_calibration_regs_bench.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/1ps
`include "mcr_defs.svh"
module metering_calibration_regs_bench;
  import mcr_pkg::*;

  // ==========================================================================
  // Signals
  logic             ref_clk_i;
  logic             rst_n_i;
  logic [8:0]       avs_address_i;
  logic             avs_read_i;
  logic             avs_write_i;
  mcr_word_t        avs_writedata_i;
  logic [3:0]       avs_byteenable_i;
  mcr_word_t        avs_readdata_o;
  logic             avs_waitrequest_o;
  mcr_word_t        pb_current_rms_result_i;
  mcr_word_t        pa_fund_irms_os_o;
  mcr_word_t        pa_fund_vrms_os_o;
  mcr_word_t        pa_hc_vrms_os_o;
  mcr_word_t        pa_hc_irms_os_o;
  mcr_word_t        pa_mc_vrms_os_o;
  mcr_word_t        pa_mc_irms_os_o;
  mcr_word_t        pb_current_gain_o;
  mcr_word_t        pb_voltage_gain_o;
  mcr_word_t        pb_irms_os_o;
  mcr_word_t        pb_vrms_os_o;
  mcr_word_t        pb_power_gain_o;
  mcr_word_t        pb_watt_os_o;
  mcr_word_t        pb_mp_gain_o;
  mcr_word_t        pb_phase_corr_o;
  mcr_band_t        pb_band_o;
  int               num_errors;
  int               n_tests;
  mcr_word_t        rd_q;
  mcr_word_t        seen;
  logic [6:0]       ix;
  logic [6:0]       idx_tab [22];
  mcr_word_t        rms_tab [5];
  mcr_band_t        band_tab [5];

  mcr_regs #(.NUM_BANDS(5)) u_mcr_regs (
    .ref_clk_i               (ref_clk_i),
    .rst_n_i                 (rst_n_i),
    .avs_address_i           (avs_address_i),
    .avs_read_i              (avs_read_i),
    .avs_write_i             (avs_write_i),
    .avs_writedata_i         (avs_writedata_i),
    .avs_byteenable_i        (avs_byteenable_i),
    .avs_readdata_o          (avs_readdata_o),
    .avs_waitrequest_o       (avs_waitrequest_o),
    .pb_current_rms_result_i (pb_current_rms_result_i),
    .pa_fund_irms_os_o       (pa_fund_irms_os_o),
    .pa_fund_vrms_os_o       (pa_fund_vrms_os_o),
    .pa_hc_vrms_os_o         (pa_hc_vrms_os_o),
    .pa_hc_irms_os_o         (pa_hc_irms_os_o),
    .pa_mc_vrms_os_o         (pa_mc_vrms_os_o),
    .pa_mc_irms_os_o         (pa_mc_irms_os_o),
    .pb_current_gain_o       (pb_current_gain_o),
    .pb_voltage_gain_o       (pb_voltage_gain_o),
    .pb_irms_os_o            (pb_irms_os_o),
    .pb_vrms_os_o            (pb_vrms_os_o),
    .pb_power_gain_o         (pb_power_gain_o),
    .pb_watt_os_o            (pb_watt_os_o),
    .pb_mp_gain_o            (pb_mp_gain_o),
    .pb_phase_corr_o         (pb_phase_corr_o),
    .pb_band_o               (pb_band_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================================
  // Helpers
  task automatic finish_test();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input mcr_word_t got, input mcr_word_t exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  // Distinct per register so a swapped address shows up
  function automatic mcr_word_t pat(input logic [6:0] idx);
    return {1'b0, idx, 8'h5A, 1'b1, idx, 8'hC3};
  endfunction

  function automatic bit port_of(input logic [6:0] idx, output mcr_word_t v);
    port_of = 1'b1;
    case (idx)
      `MCR_IDX_PA_FIRMS_OS:   v = pa_fund_irms_os_o;
      `MCR_IDX_PA_FVRMS_OS:   v = pa_fund_vrms_os_o;
      `MCR_IDX_PA_HC_VRMS_OS: v = pa_hc_vrms_os_o;
      `MCR_IDX_PA_HC_IRMS_OS: v = pa_hc_irms_os_o;
      `MCR_IDX_PA_MC_VRMS_OS: v = pa_mc_vrms_os_o;
      `MCR_IDX_PA_MC_IRMS_OS: v = pa_mc_irms_os_o;
      `MCR_IDX_PB_IGAIN:      v = pb_current_gain_o;
      `MCR_IDX_PB_VGAIN:      v = pb_voltage_gain_o;
      `MCR_IDX_PB_IRMS_OS:    v = pb_irms_os_o;
      `MCR_IDX_PB_VRMS_OS:    v = pb_vrms_os_o;
      `MCR_IDX_PB_PGAIN:      v = pb_power_gain_o;
      `MCR_IDX_PB_WATT_OS:    v = pb_watt_os_o;
      default: begin
        v = '0;
        port_of = 1'b0;
      end
    endcase
  endfunction

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [8:0] a, input mcr_word_t d,
                     input logic [3:0] be, output mcr_word_t q);
    int n;
    @(posedge ref_clk_i);
    avs_address_i    <= a;
    avs_writedata_i  <= d;
    avs_byteenable_i <= be;
    avs_write_i      <= w;
    avs_read_i       <= ~w;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      num_errors++;
      $display("Error at %0t: bus answer timed out", $time);
      finish_test();
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] idx, input mcr_word_t d,
                    input logic [3:0] be = 4'hF);
    mcr_word_t unused;
    bus(1'b1, {idx, 2'b00}, d, be, unused);
  endtask

  task automatic rd(input logic [6:0] idx, input mcr_word_t exp);
    bus(1'b0, {idx, 2'b00}, '0, 4'hF, rd_q);
    check(rd_q, exp);
  endtask

  task automatic wait_band(input mcr_band_t b);
    int n;
    for (n = 0; n < 40 && pb_band_o !== b; n++) @(negedge ref_clk_i);
    if (pb_band_o !== b) begin
      num_errors++;
      $display("Error at %0t: band wait timed out", $time);
      finish_test();
    end
    @(negedge ref_clk_i);
    check({29'h0, pb_band_o}, {29'h0, b});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    idx_tab = '{7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h20, 7'h21,
                7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h29,
                7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F};
    // Each level is chosen so the band walk ends at a known band
    rms_tab  = '{32'd1000, 32'd180, 32'd10, 32'd150, 32'd350};
    band_tab = '{3'h4, 3'h2, 3'h0, 3'h1, 3'h3};
    num_errors = 0;
    n_tests = 0;
    rst_n_i = 1'b0;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = '0;
    avs_byteenable_i = 4'hF;
    pb_current_rms_result_i = '0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;

    foreach (idx_tab[i]) begin
      rd(idx_tab[i], 32'h00000000);
      if (port_of(idx_tab[i], seen)) check(seen, 32'h00000000);
    end
    foreach (idx_tab[i]) begin
      wr(idx_tab[i], pat(idx_tab[i]));
      @(negedge ref_clk_i);
      if (port_of(idx_tab[i], seen)) begin
        check(seen, pat(idx_tab[i]));
      end
    end
    foreach (idx_tab[i]) rd(idx_tab[i], pat(idx_tab[i]));

    ix = `MCR_IDX_PB_IGAIN;
    wr(ix, 32'h11223344, 4'h5);
    seen = pat(ix);
    rd(ix, {seen[31:24], 8'h22, seen[15:8], 8'h44});
    wr(7'h00, 32'hFFFFFFFF);
    rd(7'h00, 32'h00000000);
    bus(1'b1, {`MCR_IDX_PB_PGAIN, 2'b01}, 32'h00000000, 4'hF, rd_q);
    rd(`MCR_IDX_PB_PGAIN, pat(`MCR_IDX_PB_PGAIN));

    // Multipoint off must ignore a large current
    pb_current_rms_result_i <= 32'd1000;
    repeat (10) @(negedge ref_clk_i);
    check({29'h0, pb_band_o}, 32'h00000000);
    check(pb_mp_gain_o, 32'h00000000);
    check(pb_phase_corr_o, pat(`MCR_IDX_PB_PHCORR0));
    for (int k = 0; k < 4; k++) begin
      wr(7'(`MCR_IDX_THR_LO0 + k), 32'(50 + 100 * k));
      wr(7'(`MCR_IDX_THR_HI0 + k), 32'(100 + 100 * k));
    end
    // Enable write without lane 0 must not take effect
    wr(`MCR_IDX_CONFIG, 32'h00000001, 4'hE);
    rd(`MCR_IDX_CONFIG, 32'h00000000);
    wr(`MCR_IDX_CONFIG, 32'h00000001);
    foreach (rms_tab[j]) begin
      @(posedge ref_clk_i);
      pb_current_rms_result_i <= rms_tab[j];
      wait_band(band_tab[j]);
      ix = 7'(`MCR_IDX_PB_MP_GAIN0 + band_tab[j]);
      check(pb_mp_gain_o, pat(ix));
      ix = 7'(`MCR_IDX_PB_PHCORR0 + band_tab[j]);
      check(pb_phase_corr_o, pat(ix));
      rd(`MCR_IDX_STATUS, {25'h0, band_tab[j], 4'h1});
    end
    wr(`MCR_IDX_CONFIG, 32'h00000000);
    wait_band(3'h0);
    check(pb_mp_gain_o, 32'h00000000);
    check(pb_phase_corr_o, pat(`MCR_IDX_PB_PHCORR0));

    // Second reset in mid-run clears every register again and raises waitrequest
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    @(negedge ref_clk_i);
    check(pb_power_gain_o, 32'h00000000);
    check(pb_phase_corr_o, 32'h00000000);
    check({31'h0, avs_waitrequest_o}, 32'h00000001);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(`MCR_IDX_PB_WATT_OS, 32'h00000000);
    rd(`MCR_IDX_PA_FIRMS_OS, 32'h00000000);
    finish_test();
  end
endmodule

// ===== hdl/mcr_band_if.sv
// Links the register bank to the multipoint band selector
`timescale 1ns/1ps
interface mcr_band_if #(
  parameter int NUM_BANDS = 5
);
  import mcr_pkg::*;
  mcr_word_t                 rms;
  mcr_word_t [NUM_BANDS-2:0] thr_lo;
  mcr_word_t [NUM_BANDS-2:0] thr_hi;
  logic                      enable;
  mcr_band_t                 band;

  modport sel  (input rms, thr_lo, thr_hi, enable, output band);
  modport bank (output rms, thr_lo, thr_hi, enable, input band);
endinterface

// ===== hdl/mcr_band_sel.sv
// Picks the multipoint band from the phase B current rms and thresholds
`timescale 1ns/1ps
module mcr_band_sel #(
  parameter int NUM_BANDS = 5
) (
  // Clock and reset
  input wire logic  ref_clk_i,
  input wire logic  rst_n_i,
  // Bank side
  mcr_band_if.sel   bif
);
  import mcr_pkg::*;

  typedef struct packed {
    mcr_band_t band;
  } mcr_sel_state_t;

  localparam mcr_band_t TOP_BAND = mcr_band_t'(NUM_BANDS - 1);

  mcr_sel_state_t sel_q;
  mcr_sel_state_t sel_d;

  // ========================================================================
  // Band stepping
  // Boundary k rises at thr_hi[k] and falls below thr_lo[k]; the gap is the
  // hysteresis that keeps the band from chattering. One step per clock while enabled; disabling drops straight to band 0.
  always_comb begin
    sel_d = sel_q;
    if (!bif.enable) begin
      sel_d.band = '0;
    end else if (sel_q.band < TOP_BAND &&
                 bif.rms >= bif.thr_hi[sel_q.band]) begin
      sel_d.band = sel_q.band + 3'h1;
    end else if (sel_q.band != '0 &&
                 bif.rms < bif.thr_lo[sel_q.band - 3'h1]) begin
      sel_d.band = sel_q.band - 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_q <= '0;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign bif.band = sel_q.band;

  // ========================================================================
  // Checks
  a_band_disabled_zero: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !bif.enable |=> sel_q.band == '0)
    else $error("band not zero while multipoint is off");

  a_band_single_step: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) bif.enable |=>
      (sel_q.band == $past(sel_q.band) ||
       sel_q.band == $past(sel_q.band) + 3'h1 ||
       sel_q.band == $past(sel_q.band) - 3'h1))
    else $error("band moved more than one step");

endmodule

// ===== hdl/mcr_defs.svh
// Register indices, field positions and reset values of the calibration bank
`ifndef MCR_DEFS_SVH
`define MCR_DEFS_SVH

// ==========================================================================
// Geometry
`define MCR_DATA_W            32
`define MCR_ADDR_W            9
`define MCR_IDX_W             7
`define MCR_BAND_W            3
`define MCR_MP_COEFS          5
`define MCR_NUM_CAL           22
`define MCR_RESET_WORD        32'h00000000

// ==========================================================================
// Register indices; byte address is four times the index
`define MCR_IDX_PA_FIRMS_OS   7'h13
`define MCR_IDX_PA_FVRMS_OS   7'h14
`define MCR_IDX_PA_HC_VRMS_OS 7'h15
`define MCR_IDX_PA_HC_IRMS_OS 7'h16
`define MCR_IDX_PA_MC_VRMS_OS 7'h17
`define MCR_IDX_PA_MC_IRMS_OS 7'h18
`define MCR_IDX_PB_IGAIN      7'h20
`define MCR_IDX_PB_MP_GAIN0   7'h21
`define MCR_IDX_PB_MP_GAIN1   7'h22
`define MCR_IDX_PB_MP_GAIN2   7'h23
`define MCR_IDX_PB_MP_GAIN3   7'h24
`define MCR_IDX_PB_MP_GAIN4   7'h25
`define MCR_IDX_PB_PHCORR0    7'h26
`define MCR_IDX_PB_PHCORR1    7'h27
`define MCR_IDX_PB_PHCORR2    7'h28
`define MCR_IDX_PB_PHCORR3    7'h29
`define MCR_IDX_PB_PHCORR4    7'h2A
`define MCR_IDX_PB_VGAIN      7'h2B
`define MCR_IDX_PB_IRMS_OS    7'h2C
`define MCR_IDX_PB_VRMS_OS    7'h2D
`define MCR_IDX_PB_PGAIN      7'h2E
`define MCR_IDX_PB_WATT_OS    7'h2F
`define MCR_IDX_CONFIG        7'h50
`define MCR_IDX_STATUS        7'h51
`define MCR_IDX_THR_LO0       7'h52
`define MCR_IDX_THR_HI0       7'h56

// ==========================================================================
// Fields of main_config_register and the status register
`define MCR_CFG_MP_EN_BIT     0
`define MCR_STS_MP_EN_BIT     0
`define MCR_STS_BAND_LSB      4

`endif

// ===== hdl/mcr_pkg.sv
// Types shared by the calibration register bank
package mcr_pkg;

  // ========================================================================
  // Bus slave states, Gray ordered
  typedef enum logic [1:0] {
    MCR_BUS_IDLE = 2'h0,
    MCR_BUS_ACK  = 2'h1
  } mcr_bus_state_t;

  typedef logic [31:0] mcr_word_t;
  typedef logic [2:0]  mcr_band_t;

endpackage

// ===== hdl/mcr_regs.sv
// Calibration register bank for phase A rms offsets and phase B corrections
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "mcr_defs.svh"
// What this block does
// - Multipoint on: extra gain chosen by current band
// - Multipoint off: apply first phase coefficient only
// - Multipoint on: phase coefficient chosen by band
// - Power gain scales all phase B powers
// - Offset corrects phase B total active power
// - Fundamental rms offsets for phase A I, V
// - Half-cycle rms offsets for phase A V, I
// - Multi-cycle rms offsets for phase A V, I
// - Phase B rms offsets for current, voltage
// - Current and voltage gains for phase B
module mcr_regs #(
  parameter int NUM_BANDS = 5
) (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  // Avalon-MM slave
  input  wire logic [8:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  input  wire logic [3:0]           avs_byteenable_i,
  output      mcr_pkg::mcr_word_t   avs_readdata_o,
  output      logic                 avs_waitrequest_o,
  // Metrology results used for band selection
  input  wire mcr_pkg::mcr_word_t   pb_current_rms_result_i,
  // Phase A rms offsets
  output      mcr_pkg::mcr_word_t   pa_fund_irms_os_o,
  output      mcr_pkg::mcr_word_t   pa_fund_vrms_os_o,
  output      mcr_pkg::mcr_word_t   pa_hc_vrms_os_o,
  output      mcr_pkg::mcr_word_t   pa_hc_irms_os_o,
  output      mcr_pkg::mcr_word_t   pa_mc_vrms_os_o,
  output      mcr_pkg::mcr_word_t   pa_mc_irms_os_o,
  // Phase B corrections
  output      mcr_pkg::mcr_word_t   pb_current_gain_o,
  output      mcr_pkg::mcr_word_t   pb_voltage_gain_o,
  output      mcr_pkg::mcr_word_t   pb_irms_os_o,
  output      mcr_pkg::mcr_word_t   pb_vrms_os_o,
  output      mcr_pkg::mcr_word_t   pb_power_gain_o,
  output      mcr_pkg::mcr_word_t   pb_watt_os_o,
  output      mcr_pkg::mcr_word_t   pb_mp_gain_o,
  output      mcr_pkg::mcr_word_t   pb_phase_corr_o,
  output      mcr_pkg::mcr_band_t   pb_band_o
);
  import mcr_pkg::*;

  // ========================================================================
  // Parameter check
  // Only five gain and five phase coefficients exist in the map
  if (NUM_BANDS < 2 || NUM_BANDS > `MCR_MP_COEFS) begin : g_bad_bands
    $error("NUM_BANDS must lie between 2 and 5");
  end

  localparam int NT = NUM_BANDS - 1;

  typedef logic [`MCR_IDX_W-1:0] mcr_idx_t;
  typedef logic [5:0]            mcr_slot_t;

  localparam mcr_slot_t NO_SLOT = 6'h3F;

  typedef struct packed {
    mcr_bus_state_t                     fsm;
    logic                               wait_req;
    mcr_word_t                          rdata;
    logic [`MCR_NUM_CAL-1:0][31:0]      cal;
    logic                               mp_en;
    logic [NT-1:0][31:0]                thr_lo;
    logic [NT-1:0][31:0]                thr_hi;
    mcr_word_t                          mp_gain;
    mcr_word_t                          phase;
    mcr_band_t                          band;
  } mcr_state_t;

  mcr_state_t q;
  mcr_state_t d;

  mcr_band_if #(.NUM_BANDS(NUM_BANDS)) bif ();

  // ========================================================================
  // Decoding
  // Maps a register index to its storage slot; used by the bus and by
  // every output tap, so the two can never disagree.
  function automatic mcr_slot_t cal_slot(input mcr_idx_t idx);
    cal_slot = NO_SLOT;
    if (idx >= `MCR_IDX_PA_FIRMS_OS && idx <= `MCR_IDX_PA_MC_IRMS_OS) begin
      cal_slot = 6'(idx - `MCR_IDX_PA_FIRMS_OS);
    end else if (idx >= `MCR_IDX_PB_IGAIN &&
                 idx <= `MCR_IDX_PB_WATT_OS) begin
      cal_slot = 6'(idx - `MCR_IDX_PB_IGAIN) + 6'h06;
    end
  endfunction

  // Threshold number inside a bank of NT, or NT when outside
  function automatic int thr_num(input mcr_idx_t idx, input mcr_idx_t base);
    thr_num = NT;
    if (idx >= base && int'(idx - base) < NT) begin
      thr_num = int'(idx - base);
    end
  endfunction

  function automatic mcr_word_t be_merge(input mcr_word_t old_w,
                                         input mcr_word_t new_w,
                                         input logic [3:0] be);
    be_merge = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        be_merge[8*b +: 8] = new_w[8*b +: 8];
      end
    end
  endfunction

  mcr_idx_t  bus_idx;
  logic      bus_aligned;
  mcr_slot_t bus_slot;
  int        bus_lo;
  int        bus_hi;

  assign bus_idx     = avs_address_i[8:2];
  assign bus_aligned = avs_address_i[1:0] == 2'h0;
  assign bus_slot    = bus_aligned ? cal_slot(bus_idx) : NO_SLOT;
  assign bus_lo      = bus_aligned ? thr_num(bus_idx, `MCR_IDX_THR_LO0) : NT;
  assign bus_hi      = bus_aligned ? thr_num(bus_idx, `MCR_IDX_THR_HI0) : NT;

  // Read view of the whole map; unmapped or misaligned words read zero
  function automatic mcr_word_t read_word(input mcr_state_t s,
                                          input mcr_idx_t idx,
                                          input logic ok,
                                          input mcr_slot_t slot,
                                          input int lo,
                                          input int hi);
    read_word = '0;
    if (slot != NO_SLOT) begin
      read_word = s.cal[slot];
    end else if (lo < NT) begin
      read_word = s.thr_lo[lo];
    end else if (hi < NT) begin
      read_word = s.thr_hi[hi];
    end else if (ok && idx == `MCR_IDX_CONFIG) begin
      read_word[`MCR_CFG_MP_EN_BIT] = s.mp_en;
    end else if (ok && idx == `MCR_IDX_STATUS) begin
      read_word[`MCR_STS_MP_EN_BIT] = s.mp_en;
      read_word[`MCR_STS_BAND_LSB +: 3] = s.band;
    end
  endfunction

  // ========================================================================
  // Band selector
  assign bif.rms    = pb_current_rms_result_i;
  assign bif.thr_lo = q.thr_lo;
  assign bif.thr_hi = q.thr_hi;
  assign bif.enable = q.mp_en;

  mcr_band_sel #(
    .NUM_BANDS (NUM_BANDS)
  ) u_band_sel (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .bif       (bif)
  );

  // ========================================================================
  // Next state
  always_comb begin
    d          = q;
    d.wait_req = 1'b1;
    d.band     = bif.band;
    case (q.fsm)
      MCR_BUS_IDLE: begin
        // Answer one cycle after the request is seen
        if (avs_read_i || avs_write_i) begin
          d.fsm      = MCR_BUS_ACK;
          d.wait_req = 1'b0;
          d.rdata    = avs_read_i ? read_word(q, bus_idx, bus_aligned,
                                              bus_slot, bus_lo, bus_hi)
                                  : q.rdata;
        end
      end
      MCR_BUS_ACK: begin
        // The write lands on the edge at which waitrequest is seen low
        d.fsm = MCR_BUS_IDLE;
        if (avs_write_i) begin
          if (bus_slot != NO_SLOT) begin
            d.cal[bus_slot] = be_merge(q.cal[bus_slot], avs_writedata_i,
                                       avs_byteenable_i);
          end else if (bus_lo < NT) begin
            d.thr_lo[bus_lo] = be_merge(q.thr_lo[bus_lo], avs_writedata_i,
                                        avs_byteenable_i);
          end else if (bus_hi < NT) begin
            d.thr_hi[bus_hi] = be_merge(q.thr_hi[bus_hi], avs_writedata_i,
                                        avs_byteenable_i);
          end else if (bus_aligned && bus_idx == `MCR_IDX_CONFIG &&
                       avs_byteenable_i[0]) begin
            d.mp_en = avs_writedata_i[`MCR_CFG_MP_EN_BIT];
          end
        end
      end
      default: begin
        d.fsm = MCR_BUS_IDLE;
      end
    endcase
    // Coefficients follow the band a cycle late; a band change therefore
    // reaches the datapath two clocks after the rms input crosses.
    if (q.mp_en) begin
      d.mp_gain = q.cal[cal_slot(`MCR_IDX_PB_MP_GAIN0) +
                        6'(bif.band)];
      d.phase   = q.cal[cal_slot(`MCR_IDX_PB_PHCORR0) +
                        6'(bif.band)];
    end else begin
      d.mp_gain = '0;
      d.phase   = q.cal[cal_slot(`MCR_IDX_PB_PHCORR0)];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q          <= '0;
      q.fsm      <= MCR_BUS_IDLE;
      q.wait_req <= 1'b1;
      q.cal      <= {`MCR_NUM_CAL{`MCR_RESET_WORD}};
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs, all straight from the state register
  assign avs_readdata_o    = q.rdata;
  assign avs_waitrequest_o = q.wait_req;
  assign pa_fund_irms_os_o = q.cal[cal_slot(`MCR_IDX_PA_FIRMS_OS)];
  assign pa_fund_vrms_os_o = q.cal[cal_slot(`MCR_IDX_PA_FVRMS_OS)];
  assign pa_hc_vrms_os_o   = q.cal[cal_slot(`MCR_IDX_PA_HC_VRMS_OS)];
  assign pa_hc_irms_os_o   = q.cal[cal_slot(`MCR_IDX_PA_HC_IRMS_OS)];
  assign pa_mc_vrms_os_o   = q.cal[cal_slot(`MCR_IDX_PA_MC_VRMS_OS)];
  assign pa_mc_irms_os_o   = q.cal[cal_slot(`MCR_IDX_PA_MC_IRMS_OS)];
  assign pb_current_gain_o = q.cal[cal_slot(`MCR_IDX_PB_IGAIN)];
  assign pb_voltage_gain_o = q.cal[cal_slot(`MCR_IDX_PB_VGAIN)];
  assign pb_irms_os_o      = q.cal[cal_slot(`MCR_IDX_PB_IRMS_OS)];
  assign pb_vrms_os_o      = q.cal[cal_slot(`MCR_IDX_PB_VRMS_OS)];
  assign pb_power_gain_o   = q.cal[cal_slot(`MCR_IDX_PB_PGAIN)];
  assign pb_watt_os_o      = q.cal[cal_slot(`MCR_IDX_PB_WATT_OS)];
  assign pb_mp_gain_o      = q.mp_gain;
  assign pb_phase_corr_o   = q.phase;
  assign pb_band_o         = q.band;

  // ========================================================================
  // Checks
  logic wr_full;
  assign wr_full = q.fsm == MCR_BUS_ACK && avs_write_i &&
                   avs_byteenable_i == 4'hF;

  a_ack_one_cycle: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  a_write_stores: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) wr_full && bus_slot != NO_SLOT |=>
      q.cal[$past(bus_slot)] == $past(avs_writedata_i))
    else $error("full write not stored");

  a_mp_gain_pick: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) q.mp_en |=> pb_mp_gain_o ==
      $past(q.cal[cal_slot(`MCR_IDX_PB_MP_GAIN0) + 6'(bif.band)]))
    else $error("multipoint gain does not follow band");

  a_phase_off_first: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !q.mp_en ##1 !q.mp_en |=>
      pb_phase_corr_o == $past(q.cal[cal_slot(`MCR_IDX_PB_PHCORR0)]) &&
      pb_mp_gain_o == '0)
    else $error("phase not first coefficient with multipoint off");

  a_phase_pick: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) q.mp_en |=> pb_phase_corr_o ==
      $past(q.cal[cal_slot(`MCR_IDX_PB_PHCORR0) + 6'(bif.band)]))
    else $error("phase coefficient does not follow band");

  a_power_gain_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PB_PGAIN && bus_aligned |=>
      pb_power_gain_o == $past(avs_writedata_i))
    else $error("power gain output missed write");

  a_watt_os_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PB_WATT_OS && bus_aligned |=>
      pb_watt_os_o == $past(avs_writedata_i))
    else $error("active power offset output missed write");

  a_fund_os_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PA_FIRMS_OS && bus_aligned |=>
      pa_fund_irms_os_o == $past(avs_writedata_i))
    else $error("fundamental current offset missed write");

  a_fund_v_os_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PA_FVRMS_OS && bus_aligned |=>
      pa_fund_vrms_os_o == $past(avs_writedata_i))
    else $error("fundamental voltage offset missed write");

  a_hc_v_os_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PA_HC_VRMS_OS && bus_aligned |=>
      pa_hc_vrms_os_o == $past(avs_writedata_i))
    else $error("half-cycle voltage offset missed write");

  a_hc_i_os_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PA_HC_IRMS_OS && bus_aligned |=>
      pa_hc_irms_os_o == $past(avs_writedata_i))
    else $error("half-cycle current offset missed write");

  a_mc_v_os_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PA_MC_VRMS_OS && bus_aligned |=>
      pa_mc_vrms_os_o == $past(avs_writedata_i))
    else $error("multi-cycle voltage offset missed write");

  a_mc_i_os_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PA_MC_IRMS_OS && bus_aligned |=>
      pa_mc_irms_os_o == $past(avs_writedata_i))
    else $error("multi-cycle current offset missed write");

  a_rms_os_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PB_IRMS_OS && bus_aligned |=>
      pb_irms_os_o == $past(avs_writedata_i))
    else $error("phase B current rms offset missed write");

  a_vrms_os_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PB_VRMS_OS && bus_aligned |=>
      pb_vrms_os_o == $past(avs_writedata_i))
    else $error("phase B voltage rms offset missed write");

  a_igain_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PB_IGAIN && bus_aligned |=>
      pb_current_gain_o == $past(avs_writedata_i))
    else $error("current gain output missed write");

  a_vgain_wr: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
      wr_full && bus_idx == `MCR_IDX_PB_VGAIN && bus_aligned |=>
      pb_voltage_gain_o == $past(avs_writedata_i))
    else $error("voltage gain output missed write");

endmodule
